/* include/core_regs_pkg.sv */
// constants and types shared by the core register set and its alu
package core_regs_pkg;

  // ----------------------------------------------------------------
  // widths and flag positions
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int PC_W = 16;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_I = 3;
  localparam int FLAG_H = 4;
  localparam logic [7:0] FLAGS_ONES = 8'hE0;
  localparam logic [7:0] FLAGS_RESET = 8'hE8;

  // ----------------------------------------------------------------
  // vectors and stack frame sizes
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam int NUM_IRQ = 10;
  localparam logic [15:0] IRQ_VEC [0:9] = '{
    16'hFFE2, 16'hFFE4, 16'hFFE8, 16'hFFEA, 16'hFFEC,
    16'hFFEE, 16'hFFF2, 16'hFFF4, 16'hFFF6, 16'hFFF8
  };
  localparam logic [2:0] CTX_BYTES = 3'h5;
  localparam logic [2:0] CALL_BYTES = 3'h2;

  // ----------------------------------------------------------------
  // command, operation and condition encodings
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NOP, CMD_ALU, CMD_LOAD, CMD_LOAD_PC, CMD_SET_MASK, CMD_CLR_MASK,
    CMD_SET_CARRY, CMD_RST_CARRY, CMD_PUSH_FLAGS, CMD_POP_FLAGS,
    CMD_BRANCH, CMD_BIT_TEST, CMD_TRAP, CMD_INTERRUPT_RETURN_INSTR, CMD_CALL
  } cmd_type;

  typedef enum logic [1:0] {DST_ACC, DST_X, DST_Y} dst_type;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_CP, ALU_AND, ALU_OR, ALU_XOR,
    ALU_CPL, ALU_INC, ALU_DEC, ALU_SLL, ALU_SRL, ALU_RLC, ALU_RRC, ALU_MUL
  } alu_op_type;

  typedef enum logic [3:0] {
    COND_H, COND_NH, COND_M, COND_NM, COND_MI, COND_PL,
    COND_EQ, COND_NE, COND_C, COND_NC
  } cond_type;

  typedef enum logic [1:0] {ST_RUN, ST_PUSH, ST_POP} state_type;

endpackage : core_regs_pkg

/* src/alu_unit.sv */
// combinational alu: result, carries and which flags each operation touches
`timescale 1ns/100ps
module alu_unit (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic carry_in,
  input wire core_regs_pkg::alu_op_type op,
  output logic [7:0] result,
  output logic [7:0] result_high,
  output logic half_out,
  output logic carry_out,
  output logic upd_h,
  output logic upd_c,
  output logic upd_nz,
  output logic write_res
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [15:0] prod;

  // ----------------------------------------------------------------
  // operation select
  // ----------------------------------------------------------------
  // one adder path for add and subtract keeps the carry logic shared
  always_comb begin
    sum = {1'b0, a};
    nib = 5'h00;
    prod = a * b;
    result_high = 8'h00;
    half_out = 1'b0;
    carry_out = 1'b0;
    upd_h = 1'b0;
    upd_c = 1'b0;
    upd_nz = 1'b1;
    write_res = 1'b1;
    case (op)
      core_regs_pkg::ALU_ADD, core_regs_pkg::ALU_ADC: begin
        sum = {1'b0, a} + {1'b0, b} + {8'h00, carry_in & (op == core_regs_pkg::ALU_ADC)};
        nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, carry_in & (op == core_regs_pkg::ALU_ADC)};
        half_out = nib[4];
        upd_h = 1'b1;
        upd_c = 1'b1;
      end
      core_regs_pkg::ALU_SUB, core_regs_pkg::ALU_SBC, core_regs_pkg::ALU_CP: begin
        sum = {1'b0, a} - {1'b0, b} - {8'h00, carry_in & (op == core_regs_pkg::ALU_SBC)};
        upd_c = 1'b1;
        write_res = (op != core_regs_pkg::ALU_CP);
      end
      core_regs_pkg::ALU_AND: sum = {1'b0, a & b};
      core_regs_pkg::ALU_OR: sum = {1'b0, a | b};
      core_regs_pkg::ALU_XOR: sum = {1'b0, a ^ b};
      core_regs_pkg::ALU_CPL: begin
        sum = {1'b1, ~a};
        upd_c = 1'b1;
      end
      core_regs_pkg::ALU_INC: sum = {1'b0, a + 8'h01};
      core_regs_pkg::ALU_DEC: sum = {1'b0, a - 8'h01};
      core_regs_pkg::ALU_SLL: begin
        sum = {a, 1'b0};
        upd_c = 1'b1;
      end
      core_regs_pkg::ALU_SRL: begin
        sum = {a[0], 1'b0, a[7:1]};
        upd_c = 1'b1;
      end
      core_regs_pkg::ALU_RLC: begin
        sum = {a, carry_in};
        upd_c = 1'b1;
      end
      core_regs_pkg::ALU_RRC: begin
        sum = {a[0], carry_in, a[7:1]};
        upd_c = 1'b1;
      end
      default: begin
        sum = {1'b0, prod[7:0]};
        result_high = prod[15:8];
        upd_h = 1'b1;
        upd_c = 1'b1;
        upd_nz = 1'b0;
      end
    endcase
    if (op != core_regs_pkg::ALU_MUL) begin
      carry_out = sum[8];
    end
  end

  assign result = sum[7:0];

endmodule : alu_unit

/* src/cpu_core_registers.sv */
// programmer-visible core registers, flags, context stacking and vectors
`timescale 1ns/100ps
// Notes on behaviour
// - eight-bit accumulator feeds and receives alu operations
// - two eight-bit index registers, also usable as scratch storage
// - interrupt entry and return never stack the second index register
// - sixteen-bit program counter in low and high bytes
// - registers reached only by commands, never by memory address
// - flags: top three read one, h i n z c; reset sets mask
// - flags pushable, poppable, each flag testable and settable
// - half carry from bit three on add and add-with-carry, branchable
// - mask blocks maskable requests, never the trap; set on entry
// - mask changed by set, clear and return commands, branchable
// - requests during mask are held pending until mask clears
// - entry sets mask, return restores it, so no nesting by default
// - clearing mask inside a routine lets pending requests in at the next boundary
// - negative copies bit seven of last non-multiply result, minus and plus test it
// - zero set on zero result except from multiply, equal and not-equal test it
// - carry from arithmetic, forced by set and reset, branchable
// - carry also updated by bit test, shifts and rotates
// - reset vector at top two bytes, trap vector just below
// - each peripheral source owns a fixed two-byte vector slot
// - trap is taken whatever the mask holds
// - unsigned eight by eight multiply
// - interrupt pushes five bytes, low pc first; call pushes two
module cpu_core_registers (
  input wire logic clk,
  input wire logic rst,
  input wire core_regs_pkg::cmd_type cmd,
  input wire core_regs_pkg::alu_op_type alu_op,
  input wire core_regs_pkg::dst_type dst_sel,
  input wire core_regs_pkg::cond_type cond_sel,
  input wire logic [2:0] bit_sel,
  input wire logic bit_jump_if_set,
  input wire logic [7:0] operand,
  input wire logic [15:0] pc_load,
  input wire logic boundary,
  input wire logic [9:0] irq_req,
  input wire logic pop_valid,
  input wire logic [7:0] pop_data,
  output logic [7:0] accumulator,
  output logic [7:0] index_first,
  output logic [7:0] index_second,
  output logic [15:0] program_counter,
  output logic [7:0] condition_flags,
  output logic branch_valid,
  output logic branch_taken,
  output logic push_valid,
  output logic [7:0] push_data,
  output logic vector_valid,
  output logic [15:0] vector_addr,
  output logic busy
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] acc_q, acc_d, x_q, x_d, y_q, y_d;
  logic [7:0] flags_q, flags_d, saved_q, saved_d;
  logic [15:0] pc_q, pc_d, vec_q, vec_d;
  logic [9:0] pend_q, pend_d, served;
  logic [2:0] cnt_q, cnt_d, len_q, len_d;
  logic push_valid_q, push_valid_d, vec_valid_q, vec_valid_d;
  logic br_valid_q, br_valid_d, br_taken_q, br_taken_d;
  logic [7:0] push_data_q, push_data_d;
  core_regs_pkg::state_type state_q, state_d;
  logic busy_q;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // lowest index wins: slot order doubles as fixed priority
  function automatic logic [3:0] first_set(input logic [9:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = core_regs_pkg::NUM_IRQ - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : first_set

  function automatic logic cond_true(input core_regs_pkg::cond_type c, input logic [7:0] f);
    logic t;
    case (c)
      core_regs_pkg::COND_H: t = f[core_regs_pkg::FLAG_H];
      core_regs_pkg::COND_NH: t = !f[core_regs_pkg::FLAG_H];
      core_regs_pkg::COND_M: t = f[core_regs_pkg::FLAG_I];
      core_regs_pkg::COND_NM: t = !f[core_regs_pkg::FLAG_I];
      core_regs_pkg::COND_MI: t = f[core_regs_pkg::FLAG_N];
      core_regs_pkg::COND_PL: t = !f[core_regs_pkg::FLAG_N];
      core_regs_pkg::COND_EQ: t = f[core_regs_pkg::FLAG_Z];
      core_regs_pkg::COND_NE: t = !f[core_regs_pkg::FLAG_Z];
      core_regs_pkg::COND_C: t = f[core_regs_pkg::FLAG_C];
      default: t = !f[core_regs_pkg::FLAG_C];
    endcase
    return t;
  endfunction : cond_true

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // a request taken at a boundary wins over any command in that cycle
  wire run = (state_q == core_regs_pkg::ST_RUN);
  wire masked = flags_q[core_regs_pkg::FLAG_I];
  wire take_irq = run && boundary && (|pend_q) && !masked;
  wire take_trap = run && !take_irq && (cmd == core_regs_pkg::CMD_TRAP);
  wire do_cmd = run && !take_irq;
  wire [3:0] irq_idx = first_set(pend_q);
  wire [7:0] dst_val = (dst_sel == core_regs_pkg::DST_X) ? x_q :
                       (dst_sel == core_regs_pkg::DST_Y) ? y_q : acc_q;
  wire is_mul = (alu_op == core_regs_pkg::ALU_MUL);
  wire [7:0] alu_a = is_mul ? x_q : dst_val;
  wire [7:0] alu_b = is_mul ? acc_q : operand;
  wire tested_bit = operand[bit_sel];
  wire last_byte = (cnt_q == (len_q - 3'h1));

  logic [7:0] alu_res, alu_high;
  logic alu_half, alu_carry, upd_h, upd_c, upd_nz, alu_write;

  alu_unit u_alu (
    .a(alu_a),
    .b(alu_b),
    .carry_in(flags_q[core_regs_pkg::FLAG_C]),
    .op(alu_op),
    .result(alu_res),
    .result_high(alu_high),
    .half_out(alu_half),
    .carry_out(alu_carry),
    .upd_h(upd_h),
    .upd_c(upd_c),
    .upd_nz(upd_nz),
    .write_res(alu_write)
  );

  // ----------------------------------------------------------------
  // pending requests
  // ----------------------------------------------------------------
  // a new request on the served line in the same cycle stays pending
  assign served = take_irq ? (10'h001 << irq_idx) : 10'h000;
  assign pend_d = (pend_q & ~served) | irq_req;

  // ----------------------------------------------------------------
  // next state of registers and sequencer
  // ----------------------------------------------------------------
  always_comb begin
    acc_d = acc_q;
    x_d = x_q;
    y_d = y_q;
    pc_d = pc_q;
    flags_d = flags_q;
    saved_d = saved_q;
    vec_d = vec_q;
    cnt_d = cnt_q;
    len_d = len_q;
    state_d = state_q;
    push_valid_d = 1'b0;
    push_data_d = push_data_q;
    vec_valid_d = 1'b0;
    br_valid_d = 1'b0;
    br_taken_d = br_taken_q;
    case (state_q)
      core_regs_pkg::ST_RUN: begin
        if (take_irq || take_trap) begin
          saved_d = flags_q;
          flags_d[core_regs_pkg::FLAG_I] = 1'b1;
          vec_d = take_trap ? core_regs_pkg::VEC_TRAP : core_regs_pkg::IRQ_VEC[irq_idx];
          len_d = core_regs_pkg::CTX_BYTES;
          cnt_d = 3'h0;
          state_d = core_regs_pkg::ST_PUSH;
        end else if (do_cmd) begin
          case (cmd)
            core_regs_pkg::CMD_ALU: begin
              if (upd_h) begin
                flags_d[core_regs_pkg::FLAG_H] = alu_half;
              end
              if (upd_c) begin
                flags_d[core_regs_pkg::FLAG_C] = alu_carry;
              end
              if (upd_nz) begin
                flags_d[core_regs_pkg::FLAG_N] = alu_res[7];
                flags_d[core_regs_pkg::FLAG_Z] = (alu_res == 8'h00);
              end
              if (is_mul) begin
                acc_d = alu_res;
                x_d = alu_high;
              end else if (alu_write) begin
                case (dst_sel)
                  core_regs_pkg::DST_X: x_d = alu_res;
                  core_regs_pkg::DST_Y: y_d = alu_res;
                  default: acc_d = alu_res;
                endcase
              end
            end
            core_regs_pkg::CMD_LOAD: begin
              flags_d[core_regs_pkg::FLAG_N] = operand[7];
              flags_d[core_regs_pkg::FLAG_Z] = (operand == 8'h00);
              case (dst_sel)
                core_regs_pkg::DST_X: x_d = operand;
                core_regs_pkg::DST_Y: y_d = operand;
                default: acc_d = operand;
              endcase
            end
            core_regs_pkg::CMD_LOAD_PC: pc_d = pc_load;
            core_regs_pkg::CMD_SET_MASK: flags_d[core_regs_pkg::FLAG_I] = 1'b1;
            core_regs_pkg::CMD_CLR_MASK: flags_d[core_regs_pkg::FLAG_I] = 1'b0;
            core_regs_pkg::CMD_SET_CARRY: flags_d[core_regs_pkg::FLAG_C] = 1'b1;
            core_regs_pkg::CMD_RST_CARRY: flags_d[core_regs_pkg::FLAG_C] = 1'b0;
            core_regs_pkg::CMD_PUSH_FLAGS: begin
              push_valid_d = 1'b1;
              push_data_d = flags_q;
            end
            core_regs_pkg::CMD_POP_FLAGS: flags_d = operand | core_regs_pkg::FLAGS_ONES;
            core_regs_pkg::CMD_BRANCH: begin
              br_valid_d = 1'b1;
              br_taken_d = cond_true(cond_sel, flags_q);
            end
            core_regs_pkg::CMD_BIT_TEST: begin
              flags_d[core_regs_pkg::FLAG_C] = tested_bit;
              br_valid_d = 1'b1;
              br_taken_d = (tested_bit == bit_jump_if_set);
            end
            core_regs_pkg::CMD_CALL: begin
              len_d = core_regs_pkg::CALL_BYTES;
              cnt_d = 3'h0;
              state_d = core_regs_pkg::ST_PUSH;
            end
            core_regs_pkg::CMD_INTERRUPT_RETURN_INSTR: begin
              cnt_d = 3'h0;
              state_d = core_regs_pkg::ST_POP;
            end
            default: begin
            end
          endcase
        end
      end
      core_regs_pkg::ST_PUSH: begin
        // second index register is deliberately absent from the frame
        push_valid_d = 1'b1;
        case (cnt_q)
          3'h0: push_data_d = pc_q[7:0];
          3'h1: push_data_d = pc_q[15:8];
          3'h2: push_data_d = x_q;
          3'h3: push_data_d = acc_q;
          default: push_data_d = saved_q;
        endcase
        cnt_d = cnt_q + 3'h1;
        if (last_byte) begin
          vec_valid_d = (len_q == core_regs_pkg::CTX_BYTES);
          state_d = core_regs_pkg::ST_RUN;
        end
      end
      default: begin
        // pop order mirrors the push: flags first, low pc last
        if (pop_valid) begin
          case (cnt_q)
            3'h0: flags_d = pop_data | core_regs_pkg::FLAGS_ONES;
            3'h1: acc_d = pop_data;
            3'h2: x_d = pop_data;
            3'h3: pc_d[15:8] = pop_data;
            default: pc_d[7:0] = pop_data;
          endcase
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == (core_regs_pkg::CTX_BYTES - 3'h1)) begin
            state_d = core_regs_pkg::ST_RUN;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // architectural registers
  // ----------------------------------------------------------------
  // data registers reset to zero so nothing downstream sees unknowns
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= 8'h00;
      x_q <= 8'h00;
      y_q <= 8'h00;
      pc_q <= 16'h0000;
      flags_q <= core_regs_pkg::FLAGS_RESET;
    end else begin
      acc_q <= acc_d;
      x_q <= x_d;
      y_q <= y_d;
      pc_q <= pc_d;
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------------------------------
  // sequencer and pending latches
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= core_regs_pkg::ST_RUN;
      busy_q <= 1'b0;
      cnt_q <= 3'h0;
      len_q <= 3'h0;
      saved_q <= 8'h00;
      pend_q <= 10'h000;
    end else begin
      state_q <= state_d;
      busy_q <= (state_d != core_regs_pkg::ST_RUN); // registered copy keeps the port glitch free
      cnt_q <= cnt_d;
      len_q <= len_d;
      saved_q <= saved_d;
      pend_q <= pend_d;
    end
  end

  // ----------------------------------------------------------------
  // output strobes and vector
  // ----------------------------------------------------------------
  // reset itself announces the start address once after release
  always_ff @(posedge clk) begin
    if (rst) begin
      vec_q <= core_regs_pkg::VEC_RESET;
      vec_valid_q <= 1'b1;
      push_valid_q <= 1'b0;
      push_data_q <= 8'h00;
      br_valid_q <= 1'b0;
      br_taken_q <= 1'b0;
    end else begin
      vec_q <= vec_d;
      vec_valid_q <= vec_valid_d;
      push_valid_q <= push_valid_d;
      push_data_q <= push_data_d;
      br_valid_q <= br_valid_d;
      br_taken_q <= br_taken_d;
    end
  end

  // ----------------------------------------------------------------
  // ports, all straight from flip-flops
  // ----------------------------------------------------------------
  assign accumulator = acc_q;
  assign index_first = x_q;
  assign index_second = y_q;
  assign program_counter = pc_q;
  assign condition_flags = flags_q;
  assign branch_valid = br_valid_q;
  assign branch_taken = br_taken_q;
  assign push_valid = push_valid_q;
  assign push_data = push_data_q;
  assign vector_valid = vec_valid_q;
  assign vector_addr = vec_q;
  assign busy = busy_q;

endmodule : cpu_core_registers

/* tb/core_regs_sva.sv */
// concurrent checks on the core register set ports
`timescale 1ns/100ps
module core_regs_sva (
  input wire logic clk,
  input wire logic rst,
  input wire core_regs_pkg::cmd_type cmd,
  input wire core_regs_pkg::alu_op_type alu_op,
  input wire core_regs_pkg::cond_type cond_sel,
  input wire logic boundary,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] index_first,
  input wire logic [7:0] index_second,
  input wire logic [7:0] condition_flags,
  input wire logic branch_valid,
  input wire logic branch_taken,
  input wire logic push_valid,
  input wire logic vector_valid,
  input wire logic [15:0] vector_addr,
  input wire logic busy
);
  // --------
  // helpers
  // --------
  // conservative: skip any cycle where an interrupt could steal the command
  wire logic cmd_ok = !busy && !(boundary && !condition_flags[3]);
  wire logic zero_flag = condition_flags[1];
  wire logic is_trap = cmd_ok && cmd == core_regs_pkg::CMD_TRAP;
  wire logic is_call = cmd_ok && cmd == core_regs_pkg::CMD_CALL;
  wire logic stack_cmd = cmd inside {core_regs_pkg::CMD_TRAP, core_regs_pkg::CMD_CALL, core_regs_pkg::CMD_INTERRUPT_RETURN_INSTR};

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // --------
  // assertions
  // --------
  // flag layout, reset state, mask and carry commands, equal branch and multiply
  flags_ones_a: assert property (condition_flags[7:5] == 3'h7) else $error("flag top bits not one");
  reset_state_a: assert property (disable iff (1'b0) rst |=> condition_flags == 8'hE8
    && accumulator == 8'h00 && vector_addr == 16'hFFFE) else $error("reset state wrong");
  set_mask_a: assert property (cmd_ok && cmd == core_regs_pkg::CMD_SET_MASK |=> condition_flags[3])
    else $error("mask not set");
  clr_mask_a: assert property (cmd_ok && cmd == core_regs_pkg::CMD_CLR_MASK |=> !condition_flags[3])
    else $error("mask not cleared");
  carry_cmd_a: assert property (cmd_ok && cmd inside {core_regs_pkg::CMD_SET_CARRY,
    core_regs_pkg::CMD_RST_CARRY} |=> condition_flags[0] == ($past(cmd) == core_regs_pkg::CMD_SET_CARRY))
    else $error("carry command wrong");
  branch_eq_a: assert property (cmd_ok && cmd == core_regs_pkg::CMD_BRANCH &&
    cond_sel == core_regs_pkg::COND_EQ |=> branch_valid && branch_taken == $past(zero_flag))
    else $error("equal branch wrong");
  mul_result_a: assert property (cmd_ok && cmd == core_regs_pkg::CMD_ALU &&
    alu_op == core_regs_pkg::ALU_MUL |=> {index_first, accumulator} == $past(index_first) * $past(accumulator)
    && !condition_flags[4] && !condition_flags[0]) else $error("multiply wrong");
  // stacking frames and masking
  trap_frame_a: assert property (is_trap |=> busy && !push_valid ##1 push_valid [*5] ##1 !push_valid)
    else $error("trap frame length wrong");
  trap_vector_a: assert property (is_trap |-> ##6 vector_valid && vector_addr == 16'hFFFC)
    else $error("trap vector wrong");
  call_frame_a: assert property (is_call |=> !push_valid ##1 push_valid [*2] ##1 !push_valid && !vector_valid)
    else $error("call frame wrong");
  masked_idle_a: assert property (!busy && condition_flags[3] && !stack_cmd |=> !busy)
    else $error("entry while masked");
  y_kept_a: assert property (busy |=> $stable(index_second)) else $error("second index moved");
endmodule : core_regs_sva

bind cpu_core_registers core_regs_sva chk_u (.*);

/* tb/cpu_core_registers_and_flags_test.sv */
// self-checking bench for the core register set and flags
`timescale 1ns/100ps
module cpu_core_registers_and_flags_test;
  // --------
  // stimulus, outputs and model state
  // --------
  core_regs_pkg::cmd_type cmd = core_regs_pkg::CMD_NOP;
  core_regs_pkg::alu_op_type alu_op = core_regs_pkg::ALU_ADD;
  core_regs_pkg::dst_type dst_sel = core_regs_pkg::DST_ACC;
  core_regs_pkg::cond_type cond_sel = core_regs_pkg::COND_H;
  logic clk = 1'b0, rst = 1'b1, boundary = 1'b0, bit_jump_if_set = 1'b0, pop_valid = 1'b0;
  logic [2:0] bit_sel = 3'h0;
  logic [7:0] operand = 8'h00, pop_data = 8'h00, accumulator, index_first, index_second, condition_flags;
  logic [7:0] push_data;
  logic [15:0] pc_load = 16'h0000, program_counter, vector_addr;
  logic [9:0] irq_req = 10'h000;
  logic branch_valid, branch_taken, push_valid, vector_valid, busy;
  int error_cnt = 0, samples_checked = 0, ea, ex, ey, ef, epc, a, b, c, s, v;
  int pq[$];
  int flag_bit[5] = '{4, 3, 2, 1, 0};

  always #2 clk = ~clk;

  cpu_core_registers dut_u (.*);

  // --------
  // tasks
  // --------
  task automatic chk(input string what, input int exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp[15:0]) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp[15:0], got);
    end
  endtask : chk

  task automatic regs_chk();
    chk("accumulator", ea, {8'h00, accumulator});
    chk("index_first", ex, {8'h00, index_first});
    chk("index_second", ey, {8'h00, index_second});
    chk("program_counter", epc, program_counter);
    chk("condition_flags", ef, {8'h00, condition_flags});
  endtask : regs_chk

  // commands are replaced at the next falling edge, so each is taken once
  task automatic issue(input core_regs_pkg::cmd_type cc, input logic [7:0] op);
    cmd = cc;
    operand = op;
    @(negedge clk);
  endtask : issue

  task automatic nz(input int r);
    ef = (ef & 8'hF9) | (r[7] ? 4 : 0) | (r[7:0] == 0 ? 2 : 0);
  endtask : nz

  task automatic ld(input core_regs_pkg::dst_type d, input int r);
    dst_sel = d;
    issue(core_regs_pkg::CMD_LOAD, r[7:0]);
    if (d == core_regs_pkg::DST_ACC) ea = r & 8'hFF;
    else if (d == core_regs_pkg::DST_X) ex = r & 8'hFF;
    else ey = r & 8'hFF;
    nz(r);
  endtask : ld

  // gather one stacking sequence; the frame holds flags from before entry
  task automatic frame(input int n, input int vec);
    logic [7:0] got[$];
    logic [15:0] seen;
    seen = 16'h0000;
    cmd = core_regs_pkg::CMD_NOP;
    pq = {epc & 8'hFF, epc >> 8, ex, ea, ef};
    if (n == 2) pq = pq[0:1];
    for (int i = 0; i < 9; i++) begin
      @(negedge clk);
      if (push_valid === 1'b1) got.push_back(push_data);
      if (vector_valid === 1'b1) seen = vector_addr;
    end
    chk("push count", n, 16'(got.size()));
    foreach (pq[i]) chk("push byte", pq[i], {8'h00, got[i]});
    chk("vector", vec, seen);
    if (n == 5) ef = ef | 8'h08;
    regs_chk();
  endtask : frame

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // --------
  // main sequence
  // --------
  initial begin
    void'($urandom(32'hD3BAE7D5));
    repeat (2) @(negedge clk);
    rst = 1'b0;
    {ea, ex, ey, epc, ef} = {32'h0, 32'h0, 32'h0, 32'h0, 32'hE8};
    regs_chk();
    chk("reset vector", 16'hFFFE, vector_addr);
    $display("test reset done");
    // add, add with carry, subtract and multiply; first pair crosses both carries
    for (int i = 0; i < 16; i++) begin
      a = i < 2 ? 8'h8F : $urandom & 8'hFF;
      b = i < 2 ? 8'h71 : $urandom & 8'hFF;
      ld(core_regs_pkg::DST_Y, $urandom);
      ld(core_regs_pkg::DST_X, $urandom);
      ld(core_regs_pkg::DST_ACC, a);
      alu_op = core_regs_pkg::alu_op_type'(i % 4 == 3 ? 15 : i % 4);
      c = i % 4 == 1 ? ef & 1 : 0;
      s = i % 4 == 2 ? ea - b : ea + b + c;
      issue(core_regs_pkg::CMD_ALU, b[7:0]);
      if (i % 4 == 3) begin
        s = ex * ea;
        ex = s >> 8;
        ea = s & 8'hFF;
        ef = ef & 8'hEE;
      end else if (i % 4 == 2) begin
        ef = (ef & 8'hFE) | (s < 0 ? 1 : 0);
        ea = s & 8'hFF;
        nz(s);
      end else begin
        ef = (ef & 8'hEE) | ((ea & 4'hF) + (b & 4'hF) + c > 15 ? 8'h10 : 8'h00) | (s > 255 ? 1 : 0);
        ea = s & 8'hFF;
        nz(s);
      end
      regs_chk();
    end
    $display("test alu done");
    // bit test, flag pop, carry force, every branch condition, flag push
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      bit_sel = i[2:0];
      bit_jump_if_set = v[8];
      issue(core_regs_pkg::CMD_BIT_TEST, v[7:0]);
      chk("bit branch", v[i] == v[8], {15'h0000, branch_taken});
      chk("bit carry", v[i], {15'h0000, condition_flags[0]});
      issue(core_regs_pkg::CMD_POP_FLAGS, v[16:9]);
      ef = v[16:9] | 8'hE0;
      issue(i % 2 ? core_regs_pkg::CMD_SET_CARRY : core_regs_pkg::CMD_RST_CARRY, 8'h00);
      ef = (ef & 8'hFE) | (i % 2);
      regs_chk();
      for (int k = 0; k < 10; k++) begin
        cond_sel = core_regs_pkg::cond_type'(k);
        issue(core_regs_pkg::CMD_BRANCH, 8'h00);
        chk("branch", 16'h0100 | ((ef >> flag_bit[k / 2]) & 1) ^ (k % 2), {7'h00, branch_valid, 7'h00, branch_taken});
      end
      issue(core_regs_pkg::CMD_PUSH_FLAGS, 8'h00);
      chk("pushed flags", ef | 16'h0100, {7'h00, push_valid, push_data});
    end
    $display("test flags done");
    // two requests held while masked, lower slot wins once unmasked
    issue(core_regs_pkg::CMD_SET_MASK, 8'h00);
    ef = ef | 8'h08;
    cmd = core_regs_pkg::CMD_NOP;
    irq_req = 10'h00A;
    boundary = 1'b1;
    repeat (3) @(negedge clk);
    irq_req = 10'h000;
    boundary = 1'b0;
    chk("busy while masked", 0, {15'h0000, busy});
    v = $urandom;
    pc_load = v[15:0];
    issue(core_regs_pkg::CMD_LOAD_PC, 8'h00);
    epc = v[15:0];
    issue(core_regs_pkg::CMD_CLR_MASK, 8'h00);
    ef = ef & 8'hF7;
    regs_chk();
    cmd = core_regs_pkg::CMD_NOP;
    boundary = 1'b1;
    @(negedge clk);
    boundary = 1'b0;
    frame(5, 16'hFFE4);
    // return pops flags, accumulator, first index, pc high, pc low
    issue(core_regs_pkg::CMD_INTERRUPT_RETURN_INSTR, 8'h00);
    cmd = core_regs_pkg::CMD_NOP;
    v = $urandom;
    pq = {v[7:0] & 8'hF7, v[15:8], v[23:16], v[31:24], v[7:0]};
    foreach (pq[k]) begin
      pop_valid = 1'b1;
      pop_data = pq[k][7:0];
      @(negedge clk);
    end
    pop_valid = 1'b0;
    for (int k = 0; k < 4 && busy !== 1'b0; k++) @(negedge clk);
    ef = pq[0] | 8'hE0;
    ea = pq[1];
    ex = pq[2];
    epc = pq[3] * 256 + pq[4];
    regs_chk();
    boundary = 1'b1;
    @(negedge clk);
    boundary = 1'b0;
    frame(5, 16'hFFEA);
    issue(core_regs_pkg::CMD_TRAP, 8'h00);
    frame(5, 16'hFFFC);
    issue(core_regs_pkg::CMD_CALL, 8'h00);
    frame(2, 16'h0000);
    $display("test interrupts done");
    end_of_test();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #20000;
    error_cnt++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule : cpu_core_registers_and_flags_test
